//--- shared/bia_pkg.sv
package bia_pkg;
	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int NUM_STREAMS = 32;
	localparam int WIDE_STREAMS = 16;
	localparam logic [ADDR_W-1:0] CH_OFS_BASE = 16'h0043;
	localparam logic [ADDR_W-1:0] CH_OFS_LAST = 16'h0062;
	localparam logic [ADDR_W-1:0] QB_OFS_BASE = 16'h0063;
	localparam logic [ADDR_W-1:0] QB_OFS_LAST = 16'h0082;
	localparam logic [ADDR_W-1:0] RATE_BASE = 16'h0100;
	localparam logic [ADDR_W-1:0] RATE_LAST = 16'h011f;
	localparam logic [ADDR_W-1:0] MODE_ADDR = 16'h0120;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'h0121;
	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CH_OFS_W = 9;
	localparam int QB_OFS_W = 5;
	localparam int RATE_W = 3;
	localparam logic [CH_OFS_W-1:0] CH_OFS_RST = 9'h000;
	localparam logic [QB_OFS_W-1:0] QB_OFS_RST = 5'h00;
	localparam logic [RATE_W-1:0] RATE_RST = 3'h0;
	localparam int MODE_WIDE_BIT = 0;
	localparam int STAT_FRAME_BIT = 0;
	localparam int STAT_SKID_BIT = 1;
	localparam int STAT_OUT_BIT = 2;
	// ----------------------------------------------------------------
	// stream rates: code = log2(rate / 2 Mb/s)
	// ----------------------------------------------------------------
	localparam logic [RATE_W-1:0] RATE_2M = 3'h0;
	localparam logic [RATE_W-1:0] RATE_16M = 3'h3;
	localparam logic [RATE_W-1:0] RATE_32M = 3'h4;
	// channel mask at 32 Mb/s; slower rates shift it down
	localparam logic [CH_OFS_W-1:0] CH_MASK_MAX = 9'h1ff;
	// quarter-bit divider mask; 32 Mb/s quarter is one clock here
	localparam logic [3:0] QDIV_MASK_MAX = 4'hf;
	localparam logic [1:0] QTR_PER_BIT_M1 = 2'h3;
	localparam logic [2:0] BITS_PER_CH_M1 = 3'h7;
	localparam int STRM_W = 5;
	localparam int WORD_W = STRM_W + CH_OFS_W + 8;
endpackage

//--- design/bia_align.sv
`timescale 1ns/1ps
module bia_align
	import bia_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	input wire logic frame_pulse_i,
	input wire logic [NUM_STREAMS-1:0] backplane_serial_input,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output logic [STRM_W-1:0] rx_stream_o,
	output logic [CH_OFS_W-1:0] rx_chan_o,
	output logic [7:0] rx_data_o
);
	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [CH_OFS_W-1:0] bp_input_channel_offset_reg [0:NUM_STREAMS-1];
	logic [QB_OFS_W-1:0] bp_input_sampling_offset_reg [0:NUM_STREAMS-1];
	logic [RATE_W-1:0] rate_ff [0:NUM_STREAMS-1];
	logic wide_ff;
	logic frame_seen_ff;
	logic sk_v_ff;
	logic out_v_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic [ADDR_W-1:0] ch_idx;
	logic [ADDR_W-1:0] qb_idx;
	logic [ADDR_W-1:0] rt_idx;
	logic in_ch;
	logic in_qb;
	logic in_rt;

	always_comb begin
		ch_idx = reg_addr_i - CH_OFS_BASE;
		qb_idx = reg_addr_i - QB_OFS_BASE;
		rt_idx = reg_addr_i - RATE_BASE;
		in_ch = (reg_addr_i >= CH_OFS_BASE) && (reg_addr_i <= CH_OFS_LAST);
		in_qb = (reg_addr_i >= QB_OFS_BASE) && (reg_addr_i <= QB_OFS_LAST);
		in_rt = (reg_addr_i >= RATE_BASE) && (reg_addr_i <= RATE_LAST);
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_STREAMS; i++) begin
				bp_input_channel_offset_reg[i] <= CH_OFS_RST;
				bp_input_sampling_offset_reg[i] <= QB_OFS_RST;
				rate_ff[i] <= RATE_RST;
			end
			wide_ff <= 1'b0;
		end else if (reg_wr_i) begin
			if (in_ch) begin
				bp_input_channel_offset_reg[ch_idx[STRM_W-1:0]] <=
					reg_wdata_i[CH_OFS_W-1:0];
			end
			if (in_qb) begin
				bp_input_sampling_offset_reg[qb_idx[STRM_W-1:0]] <=
					reg_wdata_i[QB_OFS_W-1:0];
			end
			if (in_rt) begin
				rate_ff[rt_idx[STRM_W-1:0]] <= reg_wdata_i[RATE_W-1:0];
			end
			if (reg_addr_i == MODE_ADDR) begin
				wide_ff <= reg_wdata_i[MODE_WIDE_BIT];
			end
		end
	end

	// reserved bits read as zero; unmapped addresses read zero
	always_comb begin
		nxt_rdata = '0;
		if (in_ch) begin
			nxt_rdata[CH_OFS_W-1:0] =
				bp_input_channel_offset_reg[ch_idx[STRM_W-1:0]];
		end else if (in_qb) begin
			nxt_rdata[QB_OFS_W-1:0] =
				bp_input_sampling_offset_reg[qb_idx[STRM_W-1:0]];
		end else if (in_rt) begin
			nxt_rdata[RATE_W-1:0] = rate_ff[rt_idx[STRM_W-1:0]];
		end else if (reg_addr_i == MODE_ADDR) begin
			nxt_rdata[MODE_WIDE_BIT] = wide_ff;
		end else if (reg_addr_i == STATUS_ADDR) begin
			nxt_rdata[STAT_FRAME_BIT] = frame_seen_ff;
			nxt_rdata[STAT_SKID_BIT] = sk_v_ff;
			nxt_rdata[STAT_OUT_BIT] = out_v_ff;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? nxt_rdata : '0;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// a level is accepted only once stages two and three agree
	logic fp_s1_ff;
	logic fp_s2_ff;
	logic fp_s3_ff;
	logic fp_lvl_ff;
	logic fstart;
	logic [NUM_STREAMS-1:0] ser_s1_ff;
	logic [NUM_STREAMS-1:0] ser_s2_ff;
	logic [NUM_STREAMS-1:0] ser_s3_ff;
	logic [NUM_STREAMS-1:0] ser_lvl_ff;
	logic [3:0] cyc_ff;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fp_s1_ff <= 1'b0;
			fp_s2_ff <= 1'b0;
			fp_s3_ff <= 1'b0;
			fp_lvl_ff <= 1'b0;
			ser_s1_ff <= '0;
			ser_s2_ff <= '0;
			ser_s3_ff <= '0;
			ser_lvl_ff <= '0;
		end else begin
			fp_s1_ff <= frame_pulse_i;
			fp_s2_ff <= fp_s1_ff;
			fp_s3_ff <= fp_s2_ff;
			if (fp_s2_ff == fp_s3_ff) begin
				fp_lvl_ff <= fp_s3_ff;
			end
			ser_s1_ff <= backplane_serial_input;
			ser_s2_ff <= ser_s1_ff;
			ser_s3_ff <= ser_s2_ff;
			for (int i = 0; i < NUM_STREAMS; i++) begin
				if (ser_s2_ff[i] == ser_s3_ff[i]) begin
					ser_lvl_ff[i] <= ser_s3_ff[i];
				end
			end
		end
	end

	assign fstart = (fp_s2_ff == fp_s3_ff) && fp_s3_ff && !fp_lvl_ff;

	// quarter-bit divider, restarted at every frame boundary
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cyc_ff <= 4'h0;
			frame_seen_ff <= 1'b0;
		end else begin
			cyc_ff <= fstart ? 4'h0 : cyc_ff + 4'h1;
			if (fstart) begin
				frame_seen_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// per-stream aligners
	// ----------------------------------------------------------------
	logic [QB_OFS_W-1:0] abd_ff [0:NUM_STREAMS-1];
	logic [CH_OFS_W-1:0] acd_ff [0:NUM_STREAMS-1];
	logic [RATE_W-1:0] aeff_ff [0:NUM_STREAMS-1];
	logic run_ff [0:NUM_STREAMS-1];
	logic armed_ff [0:NUM_STREAMS-1];
	logic [QB_OFS_W-1:0] wait_ff [0:NUM_STREAMS-1];
	logic [1:0] q_ff [0:NUM_STREAMS-1];
	logic [2:0] bit_ff [0:NUM_STREAMS-1];
	logic [7:0] shift_ff [0:NUM_STREAMS-1];
	logic [CH_OFS_W-1:0] chan_ff [0:NUM_STREAMS-1];
	logic pend_ff [0:NUM_STREAMS-1];
	logic [7:0] byte_ff [0:NUM_STREAMS-1];
	logic [CH_OFS_W-1:0] chnum_ff [0:NUM_STREAMS-1];
	logic [STRM_W-1:0] scan_ff;
	logic push;

	genvar g;
	for (g = 0; g < NUM_STREAMS; g++) begin : g_strm
		logic en;
		logic [RATE_W-1:0] eff;
		logic [CH_OFS_W-1:0] fmask;
		logic [3:0] qmask;
		logic qtick;
		logic smp;
		logic take;

		always_comb begin
			// wide mode runs only the lower sixteen streams
			en = !wide_ff || (g < WIDE_STREAMS);
			if (wide_ff) begin
				eff = RATE_32M;
			end else if (rate_ff[g] > RATE_16M) begin
				eff = RATE_16M;
			end else begin
				eff = rate_ff[g];
			end
			fmask = CH_MASK_MAX >> (RATE_32M - eff);
			qmask = QDIV_MASK_MAX >> aeff_ff[g];
			qtick = run_ff[g] && ((cyc_ff & qmask) == 4'h0);
			smp = qtick && (armed_ff[g] ? (wait_ff[g] == abd_ff[g])
				: (q_ff[g] == QTR_PER_BIT_M1));
			take = push && (scan_ff == STRM_W'(g));
		end

		always_ff @(posedge ref_clk_i) begin
			if (rst_i || !en) begin
				abd_ff[g] <= QB_OFS_RST;
				acd_ff[g] <= CH_OFS_RST;
				aeff_ff[g] <= RATE_2M;
				run_ff[g] <= 1'b0;
				armed_ff[g] <= 1'b0;
				wait_ff[g] <= '0;
				q_ff[g] <= 2'h0;
				bit_ff[g] <= 3'h0;
				shift_ff[g] <= 8'h00;
				chan_ff[g] <= '0;
			end else if (fstart) begin
				// offsets and rate latched only here
				abd_ff[g] <= bp_input_sampling_offset_reg[g];
				acd_ff[g] <= bp_input_channel_offset_reg[g] & fmask;
				aeff_ff[g] <= eff;
				run_ff[g] <= 1'b1;
				armed_ff[g] <= 1'b1;
				wait_ff[g] <= '0;
				q_ff[g] <= 2'h0;
				bit_ff[g] <= 3'h0;
				chan_ff[g] <= '0;
			end else if (qtick) begin
				if (smp) begin
					armed_ff[g] <= 1'b0;
					q_ff[g] <= 2'h0;
					bit_ff[g] <= bit_ff[g] + 3'h1;
					shift_ff[g] <= {shift_ff[g][6:0], ser_lvl_ff[g]};
					if (bit_ff[g] == BITS_PER_CH_M1) begin
						chan_ff[g] <= chan_ff[g] + 9'h001;
					end
				end else if (armed_ff[g]) begin
					wait_ff[g] <= wait_ff[g] + 5'h01;
				end else begin
					q_ff[g] <= q_ff[g] + 2'h1;
				end
			end
		end

		// a completed byte wins over a same-cycle take
		always_ff @(posedge ref_clk_i) begin
			if (rst_i || !en) begin
				pend_ff[g] <= 1'b0;
				byte_ff[g] <= 8'h00;
				chnum_ff[g] <= '0;
			end else if (smp && !fstart && bit_ff[g] == BITS_PER_CH_M1) begin
				pend_ff[g] <= 1'b1;
				byte_ff[g] <= {shift_ff[g][6:0], ser_lvl_ff[g]};
				// channel k of the wire is stored as k minus offset
				chnum_ff[g] <= (chan_ff[g] - acd_ff[g])
					& (CH_MASK_MAX >> (RATE_32M - aeff_ff[g]));
			end else if (take) begin
				pend_ff[g] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// scanner and two-entry output buffer
	// ----------------------------------------------------------------
	// one stream is looked at per clock; a byte lasts at least 32
	// clocks, so a pending byte is visited before the next one lands
	logic [WORD_W-1:0] in_word;
	logic [WORD_W-1:0] sk_ff;
	logic in_ready;

	assign in_ready = !sk_v_ff;
	assign push = pend_ff[scan_ff] && in_ready;
	assign in_word = {scan_ff, chnum_ff[scan_ff], byte_ff[scan_ff]};

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			scan_ff <= '0;
		end else begin
			scan_ff <= scan_ff + 5'h01;
		end
	end

	// stall by the receiver parks one word in the skid slot and
	// stops the scanner from taking further bytes
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			out_v_ff <= 1'b0;
			sk_v_ff <= 1'b0;
			sk_ff <= '0;
			rx_stream_o <= '0;
			rx_chan_o <= '0;
			rx_data_o <= 8'h00;
		end else if (!out_v_ff || rx_ready_i) begin
			out_v_ff <= sk_v_ff || push;
			sk_v_ff <= 1'b0;
			if (sk_v_ff) begin
				{rx_stream_o, rx_chan_o, rx_data_o} <= sk_ff;
			end else if (push) begin
				{rx_stream_o, rx_chan_o, rx_data_o} <= in_word;
			end
		end else if (push) begin
			sk_ff <= in_word;
			sk_v_ff <= 1'b1;
		end
	end

	assign rx_valid_o = out_v_ff;
endmodule

//--- tb/bia_asserts.sv
`timescale 1ns/1ps
// ---
// port checker
// ---
module bia_asserts
	import bia_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic [STRM_W-1:0] rx_stream_o,
	input wire logic [CH_OFS_W-1:0] rx_chan_o,
	input wire logic [7:0] rx_data_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic in_ch, in_qb, wide_ff;
	logic [CH_OFS_W-1:0] wch;
	logic [QB_OFS_W-1:0] wqb;
	assign in_ch = reg_addr_i >= CH_OFS_BASE && reg_addr_i <= CH_OFS_LAST;
	assign in_qb = reg_addr_i >= QB_OFS_BASE && reg_addr_i <= QB_OFS_LAST;
	assign wch = reg_wdata_i[CH_OFS_W-1:0];
	assign wqb = reg_wdata_i[QB_OFS_W-1:0];
	// mode copy, so the stream range can be judged
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) wide_ff <= 1'b0;
		else if (reg_wr_i && reg_addr_i == MODE_ADDR) begin
			wide_ff <= reg_wdata_i[MODE_WIDE_BIT];
		end
	end
	a_unmapped_rd: assert property (reg_rd_i && reg_addr_i < CH_OFS_BASE
		|=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
	a_ch_resv: assert property (reg_rd_i && in_ch
		|=> reg_rdata_o[15:9] == 7'h00) else $error("channel reserved bits");
	a_qb_resv: assert property (reg_rd_i && in_qb
		|=> reg_rdata_o[15:5] == 11'h000) else $error("quarter reserved bits");
	a_ch_wr_rd: assert property (reg_wr_i && in_ch ##1 reg_rd_i &&
		$stable(reg_addr_i) |=> reg_rdata_o[8:0] == $past(wch, 2))
		else $error("channel offset readback");
	a_qb_wr_rd: assert property (reg_wr_i && in_qb ##1 reg_rd_i &&
		$stable(reg_addr_i) |=> reg_rdata_o[4:0] == $past(wqb, 2))
		else $error("quarter offset readback");
	a_hold_word: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o
		&& $stable(rx_data_o) && $stable(rx_chan_o) && $stable(rx_stream_o))
		else $error("word changed under stall");
	a_wide_streams: assert property (wide_ff && rx_valid_o
		|-> rx_stream_o < 5'h10) else $error("upper stream in wide mode");
	a_quiet_reset: assert property ($fell(rst_i) |-> !rx_valid_o [*4])
		else $error("word before any frame");
	c_write: cover property (reg_wr_i && in_ch);
	c_stall: cover property (rx_valid_o && !rx_ready_i);
	c_word: cover property (rx_valid_o && rx_ready_i);
	c_upper: cover property (rx_valid_o && rx_stream_o[4]);
endmodule

//--- tb/bia_src.sv
`timescale 1ns/1ps
// ---
// backplane transmitter model: one bit is four clocks << rate_sh_i
// ---
module bia_src
	import bia_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic en_i,
	input wire logic [2:0] rate_sh_i,
	output logic frame_pulse_o,
	output logic frame_start_o,
	output logic [NUM_STREAMS-1:0] serial_o
);
	logic [13:0] pos_ff;
	logic tgl_ff = 1'b0;
	logic [2:0] sh_ff;
	logic [13:0] bpos;
	logic [7:0] b;
	function automatic logic [7:0] pat(input logic [4:0] s, input logic [8:0] c);
		return c[7:0] ^ {s, 3'h0};
	endfunction
	// frame of 16384 clocks (512 channels at rate_sh_i zero) wraps by itself
	always_ff @(posedge ref_clk_i) begin
		pos_ff <= en_i ? pos_ff + 14'h0001 : 14'h0000;
		tgl_ff <= ~tgl_ff;
		// rate changes only at a frame boundary, as the receiver expects
		if (!en_i || pos_ff == 14'h3fff) begin
			sh_ff <= rate_sh_i;
		end
	end
	assign frame_pulse_o = en_i && pos_ff < 14'h0004;
	assign frame_start_o = en_i && pos_ff == 14'h0000;
	// upper streams are driven too; wide mode must ignore them
	always_comb begin
		bpos = pos_ff >> sh_ff;
		for (int s = 0; s < NUM_STREAMS; s++) begin
			b = pat(5'(s), bpos[13:5]);
			serial_o[s] = en_i ? b[~bpos[4:2]] : tgl_ff;
		end
	end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import bia_pkg::*;
;
	logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, frame_pulse_i, rx_valid_o;
	logic rx_ready_i, src_en, fstart, started, wide_act, wide_new;
	logic [2:0] src_sh, sh_act, sh_new;
	logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, two, d;
	logic [31:0] backplane_serial_input;
	logic [4:0] rx_stream_o;
	logic [8:0] rx_chan_o, w, w1;
	logic [7:0] rx_data_o;
	logic [8:0] ch_act[32], ch_new[32];
	logic [4:0] qb_act[32], qb_new[32];
	int n_errors, n_checks, quiet;
	bia_align i_bia_align(.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.frame_pulse_i(frame_pulse_i),
		.backplane_serial_input(backplane_serial_input),
		.rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
		.rx_stream_o(rx_stream_o), .rx_chan_o(rx_chan_o), .rx_data_o(rx_data_o));
	bia_src i_bia_src(.ref_clk_i(ref_clk_i), .en_i(src_en),
		.rate_sh_i(src_sh),
		.frame_pulse_o(frame_pulse_i), .frame_start_o(fstart),
		.serial_o(backplane_serial_input));
	// ---
	// helpers
	// ---
	task bad(input string m);
		n_errors++;
		$display("BAD %0t %s", $time, m);
	endtask
	task cmp_reg(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) bad($sformatf("reg got %h exp %h", g, e));
	endtask
	task cmp_word(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) bad($sformatf("byte got %h exp %h", g, e));
	endtask
	task wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		@(posedge ref_clk_i);
		v = reg_rdata_o;
	endtask
	// write, then read back in the very next cycle
	task wr_rd(input logic [15:0] a, input logic [15:0] v,
		output logic [15:0] r);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		@(posedge ref_clk_i);
		r = reg_rdata_o;
	endtask
	task wait_fs;
		for (int i = 0; i < 20000 && !fstart; i++) @(posedge ref_clk_i);
		if (!fstart) begin
			bad("no frame start");
			print_verdict();
		end
		@(posedge ref_clk_i);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ---
	// scenarios
	// ---
	task t_reg_map;
		logic [15:0] adr[6] = '{16'h0043, 16'h0062, 16'h0063, 16'h0082,
			16'h0042, 16'h0083};
		logic [15:0] msk[6] = '{16'h01ff, 16'h01ff, 16'h001f, 16'h001f,
			16'h0000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			rd(adr[i], d);
			cmp_reg(d, 16'h0000);
			wr_rd(adr[i], 16'hffff, d);
			cmp_reg(d, msk[i]);
			wr(adr[i], 16'h0000);
		end
	endtask
	task t_start;
		repeat (200) @(posedge ref_clk_i);
		wr(MODE_ADDR, 16'h0001);
		src_en <= 1'b1;
		started = 1'b1;
		repeat (3000) @(posedge ref_clk_i);
	endtask
	task t_new_offsets;
		wr(CH_OFS_BASE, 16'h0003);
		ch_new[0] = 9'h003;
		wr(CH_OFS_BASE + 16'h0007, 16'h01ff);
		ch_new[7] = 9'h1ff;
		wr(QB_OFS_BASE + 16'h0001, 16'h0004);
		qb_new[1] = 5'h04;
		wr(QB_OFS_BASE + 16'h0009, 16'h0004);
		qb_new[9] = 5'h04;
		wait_fs();
		wait_fs();
	endtask
	task t_stall;
		rx_ready_i <= 1'b0;
		repeat (40) @(posedge ref_clk_i);
		rd(STATUS_ADDR, d);
		cmp_reg(d, 16'h0007);
		rx_ready_i <= 1'b1;
		repeat (200) @(posedge ref_clk_i);
	endtask
	task t_slow_rate;
		wr(MODE_ADDR, 16'h0000);
		for (int i = 0; i < NUM_STREAMS; i++) begin
			wr(RATE_BASE + 16'(i), 16'h0001);
		end
		// 4 Mb/s on all 32 streams from the next frame on
		src_sh <= RATE_32M - 3'h1;
		wide_new = 1'b0;
		sh_new = RATE_32M - 3'h1;
		wait_fs();
		wait_fs();
	endtask
	// ---
	// word monitor; words near a frame edge may carry either setting
	// ---
	always @(posedge ref_clk_i) begin
		if (fstart) begin
			ch_act <= ch_new;
			qb_act <= qb_new;
			wide_act <= wide_new;
			sh_act <= sh_new;
			quiet <= 64;
		end else if (quiet > 0) quiet <= quiet - 1;
		if (!rst_i && rx_valid_o && rx_ready_i) begin
			if (!started || (wide_act && rx_stream_o[4])) begin
				bad("unexpected word");
			end
			// channels per frame shrink with the stream rate
			w = (rx_chan_o + ch_act[rx_stream_o]) & (CH_MASK_MAX >> sh_act);
			w1 = (w + 9'h001) & (CH_MASK_MAX >> sh_act);
			two = {i_bia_src.pat(rx_stream_o, w),
				i_bia_src.pat(rx_stream_o, w1)} << qb_act[rx_stream_o][4:2];
			if (quiet == 0) cmp_word(rx_data_o, two[15:8]);
		end
	end
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		bad("run too long");
		print_verdict();
	end
	initial begin
		{rst_i, rx_ready_i} = 2'b11;
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
		{src_en, started, n_errors, n_checks, quiet} = '0;
		{wide_act, wide_new} = 2'b11;
		{src_sh, sh_act, sh_new} = '0;
		ch_act = '{default: '0};
		ch_new = '{default: '0};
		qb_act = '{default: '0};
		qb_new = '{default: '0};
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reg_map();
		t_start();
		t_new_offsets();
		t_stall();
		t_slow_rate();
		print_verdict();
	end
endmodule
bind bia_align bia_asserts i_bia_asserts(.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_valid_o(rx_valid_o),
	.rx_ready_i(rx_ready_i), .rx_stream_o(rx_stream_o),
	.rx_chan_o(rx_chan_o), .rx_data_o(rx_data_o));
